/* File: logic/enc_pkg.sv */
/*
 * Constants for the quadrature encoder counter: register offsets,
 * field positions, reset values and filter timing.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
// What this block does
// - Index event clears or latches position
// - Single-shot mode disarms after first event
// - Index accepted only at configured A/B levels
// - Clear needs clear flag plus armed mode
// - Each change of A or B alone adds or subtracts step; both changing together is ignored
// - Step is signed sixteen-dot-sixteen fixed point
// - Decimal mode fraction counts ten-thousandths
// - Position counter readable at any time
// - Selectable polarity for A, B and index
// - Latch holds position, resets to zero
// - Event flag cleared by read, read wins
// - Interrupt output raised on index event
// - Counting rate limited by input filtering
// - Three-clock spike filter on the A, B and index inputs
package enc_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_POS = 8'h04;
    localparam logic [7:0] OFS_STEP = 8'h08;
    localparam logic [7:0] OFS_LATCH = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    // ---------------------------------------------------------------
    // Fields of encoder_mode_config
    // ---------------------------------------------------------------
    localparam int MODE_W = 9;
    localparam int B_POL_A = 0;
    localparam int B_POL_B = 1;
    localparam int B_POL_N = 2;
    localparam int B_AB_QUAL = 3;
    localparam int B_CLR_CONT = 4;
    localparam int B_CLR_ONCE = 5;
    localparam int B_CLR_POS = 6;
    localparam int B_DEC_MODE = 7;
    localparam int B_AB_INV = 8;
    localparam logic [8:0] MODE_RST = 9'h000;
    localparam logic [31:0] STEP_RST = 32'h0001_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // ---------------------------------------------------------------
    // Filter and arithmetic
    // ---------------------------------------------------------------
    localparam int FILT_LEN = 3;
    localparam logic [16:0] DEC_BASE = 17'h0_2710;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : enc_pkg

/* File: logic/abn_quadrature_encoder_counter.sv */
/*
 * Quadrature encoder counter with index handling and an AXI4-Lite
 * register slave.
 * Assumes A, B and N inputs are synchronous to mclk_in.
 */
`timescale 1ns/1ps
module abn_quadrature_encoder_counter #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic enc_n_in,
    input wire logic s_axi_awvalid_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_rready_in,
    output logic s_axi_awready_out,
    output logic s_axi_wready_out,
    output logic s_axi_bvalid_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_arready_out,
    output logic s_axi_rvalid_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic irq_out
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0][enc_pkg::FILT_LEN-1:0] hist;
        logic [2:0] filt;
        logic [enc_pkg::MODE_W-1:0] mode;
        logic [31:0] step;
        logic [31:0] pos_i;
        logic [15:0] pos_f;
        logic [31:0] latch;
        logic stat;
        logic mask;
        logic aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } state_s;

    localparam state_s STATE_RST = '{
        hist: '0, filt: '0, mode: enc_pkg::MODE_RST,
        step: enc_pkg::STEP_RST, pos_i: enc_pkg::WORD_RST,
        pos_f: 16'h0000, latch: enc_pkg::WORD_RST, stat: 1'b0,
        mask: 1'b0, aw_have: 1'b0, awaddr: '0, w_have: 1'b0,
        wdata: enc_pkg::WORD_RST, wstrb: 4'h0, awready: 1'b1,
        wready: 1'b1, bvalid: 1'b0, bresp: enc_pkg::RESP_OKAY,
        arready: 1'b1, rvalid: 1'b0, rdata: enc_pkg::WORD_RST,
        rresp: enc_pkg::RESP_OKAY, irq: 1'b0
    };

    state_s s_r;
    state_s s_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                res[k*8 +: 8] = new_v[k*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // ---------------------------------------------------------------
    // Input spike filter
    // ---------------------------------------------------------------
    // A level passes only after it has been seen on FILT_LEN
    // consecutive samples; shorter pulses never reach the decoder,
    // which also caps the sustained counting rate.
    logic [2:0] raw;
    logic [2:0][enc_pkg::FILT_LEN-1:0] hist_nxt;
    logic [2:0] filt_nxt;
    assign raw = {enc_n_in, enc_b_in, enc_a_in};

    for (genvar i = 0; i < 3; i++) begin : g_filt
        assign hist_nxt[i] = {s_r.hist[i][enc_pkg::FILT_LEN-2:0], raw[i]};
        assign filt_nxt[i] = (&hist_nxt[i]) ? 1'b1 :
            ((~|hist_nxt[i]) ? 1'b0 : s_r.filt[i]);
    end

    // ---------------------------------------------------------------
    // Decode and accumulate
    // ---------------------------------------------------------------
    logic inv;
    logic a_x;
    logic b_x;
    logic a_chg;
    logic b_chg;
    logic step_ev;
    logic up;
    logic [47:0] bin_sum;
    logic [16:0] f_add;
    logic [16:0] f_up;
    logic [16:0] f_dn;
    logic carry;
    logic borrow;
    logic [31:0] c_int;
    logic [31:0] i_up;
    logic [31:0] i_dn;
    logic n_new;
    logic n_old;
    logic qual_ok;
    logic idx;
    logic wr_go;
    logic rd_go;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] mode_wr;

    always_comb begin
        inv = s_r.mode[enc_pkg::B_AB_INV];
        a_x = filt_nxt[0] ^ inv;
        b_x = filt_nxt[1] ^ inv;
        a_chg = filt_nxt[0] ^ s_r.filt[0];
        b_chg = filt_nxt[1] ^ s_r.filt[1];
        step_ev = a_chg ^ b_chg;
        up = a_chg ? (a_x ^ b_x) : ~(a_x ^ b_x);
        // Binary mode: one signed 48-bit add or subtract of the 16.16 step.
        if (up) begin
            bin_sum = {s_r.pos_i, s_r.pos_f}
                + {{16{s_r.step[31]}}, s_r.step};
        end else begin
            bin_sum = {s_r.pos_i, s_r.pos_f}
                - {{16{s_r.step[31]}}, s_r.step};
        end
        // Decimal mode: fraction wraps at ten thousand.
        c_int = {{16{s_r.step[31]}}, s_r.step[31:16]};
        f_add = {1'b0, s_r.pos_f} + {1'b0, s_r.step[15:0]};
        carry = f_add >= enc_pkg::DEC_BASE;
        f_up = carry ? f_add - enc_pkg::DEC_BASE : f_add;
        borrow = s_r.pos_f < s_r.step[15:0];
        f_dn = {1'b0, s_r.pos_f} - {1'b0, s_r.step[15:0]};
        if (borrow) begin
            f_dn = f_dn + enc_pkg::DEC_BASE;
        end
        i_up = s_r.pos_i + c_int + {31'h0000_0000, carry};
        i_dn = s_r.pos_i - c_int - {31'h0000_0000, borrow};
        // Index: active edge of N, optionally qualified by A and B.
        n_new = filt_nxt[2] == s_r.mode[enc_pkg::B_POL_N];
        n_old = s_r.filt[2] == s_r.mode[enc_pkg::B_POL_N];
        qual_ok = ~s_r.mode[enc_pkg::B_AB_QUAL]
            | ((a_x == s_r.mode[enc_pkg::B_POL_A])
            & (b_x == s_r.mode[enc_pkg::B_POL_B]));
        idx = n_new & ~n_old & qual_ok
            & (s_r.mode[enc_pkg::B_CLR_CONT]
            | s_r.mode[enc_pkg::B_CLR_ONCE]);
        wr_go = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
        rd_go = s_r.arready & s_axi_arvalid_in;
        wa = 8'(s_r.awaddr);
        ra = 8'(s_axi_araddr_in);

        s_nxt = s_r;
        s_nxt.hist = hist_nxt;
        s_nxt.filt = filt_nxt;

        if (step_ev) begin
            if (!s_r.mode[enc_pkg::B_DEC_MODE]) begin
                s_nxt.pos_i = bin_sum[47:16];
                s_nxt.pos_f = bin_sum[15:0];
            end else if (up) begin
                s_nxt.pos_i = i_up;
                s_nxt.pos_f = f_up[15:0];
            end else begin
                s_nxt.pos_i = i_dn;
                s_nxt.pos_f = f_dn[15:0];
            end
        end

        if (idx) begin
            s_nxt.latch = s_r.pos_i;
            s_nxt.stat = 1'b1;
            if (s_r.mode[enc_pkg::B_CLR_POS]) begin
                s_nxt.pos_i = 32'h0000_0000;
                s_nxt.pos_f = 16'h0000;
            end
            s_nxt.mode[enc_pkg::B_CLR_ONCE] = 1'b0;
        end

        // Merged image of a mode write. It is built after the index
        // update, so a same-cycle write overrides the single-shot clear.
        mode_wr = merge({23'h00_0000, s_nxt.mode}, s_r.wdata, s_r.wstrb);

        // Write channels are taken independently, then committed.
        if (s_r.awready && s_axi_awvalid_in) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.awaddr = s_axi_awaddr_in;
            s_nxt.awready = 1'b0;
        end
        if (s_r.wready && s_axi_wvalid_in) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata = s_axi_wdata_in;
            s_nxt.wstrb = s_axi_wstrb_in;
            s_nxt.wready = 1'b0;
        end
        if (wr_go) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = enc_pkg::RESP_OKAY;
            if (wa == enc_pkg::OFS_MODE) begin
                s_nxt.mode = mode_wr[enc_pkg::MODE_W-1:0];
            end else if (wa == enc_pkg::OFS_STEP) begin
                s_nxt.step = merge(s_r.step, s_r.wdata, s_r.wstrb);
            end else if (wa == enc_pkg::OFS_STAT) begin
                if (s_r.wstrb[0] && s_r.wdata[0]) begin
                    s_nxt.stat = 1'b0;
                end
            end else if (wa == enc_pkg::OFS_MASK) begin
                if (s_r.wstrb[0]) begin
                    s_nxt.mask = s_r.wdata[0];
                end
            end else if (wa == enc_pkg::OFS_POS
                || wa == enc_pkg::OFS_LATCH) begin
                s_nxt.bresp = enc_pkg::RESP_OKAY;
            end else begin
                s_nxt.bresp = enc_pkg::RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_axi_bready_in) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        if (rd_go) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = enc_pkg::RESP_OKAY;
            if (ra == enc_pkg::OFS_MODE) begin
                s_nxt.rdata = {23'h00_0000, s_r.mode};
            end else if (ra == enc_pkg::OFS_POS) begin
                s_nxt.rdata = s_r.pos_i;
            end else if (ra == enc_pkg::OFS_STEP) begin
                s_nxt.rdata = s_r.step;
            end else if (ra == enc_pkg::OFS_LATCH) begin
                s_nxt.rdata = s_r.latch;
            end else if (ra == enc_pkg::OFS_STAT) begin
                s_nxt.rdata = {31'h0000_0000, s_r.stat};
                // A coinciding index event is lost here.
                s_nxt.stat = 1'b0;
            end else if (ra == enc_pkg::OFS_MASK) begin
                s_nxt.rdata = {31'h0000_0000, s_r.mask};
            end else begin
                s_nxt.rdata = 32'h0000_0000;
                s_nxt.rresp = enc_pkg::RESP_SLVERR;
            end
        end
        if (s_r.rvalid && s_axi_rready_in) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end

        s_nxt.irq = s_nxt.stat & s_nxt.mask;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Every output is a plain copy of a state flop.
    assign s_axi_awready_out = s_r.awready;
    assign s_axi_wready_out = s_r.wready;
    assign s_axi_bvalid_out = s_r.bvalid;
    assign s_axi_bresp_out = s_r.bresp;
    assign s_axi_arready_out = s_r.arready;
    assign s_axi_rvalid_out = s_r.rvalid;
    assign s_axi_rdata_out = s_r.rdata;
    assign s_axi_rresp_out = s_r.rresp;
    assign irq_out = s_r.irq;
endmodule : abn_quadrature_encoder_counter

/* File: test/enc_model.sv */
/* Encoder partner: drives quadrature A/B and index N levels.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module enc_model (
    input wire logic clk_in,
    output logic a_out,
    output logic b_out,
    output logic n_out
);
    logic [1:0] ph_r = 2'h0;
    logic n_r = 1'b0;
    // Phase order 00, 10, 11, 01 on A, B counts up.
    assign a_out = ph_r[1] ^ ph_r[0];
    assign b_out = ph_r[1];
    assign n_out = n_r;
    // An increment of two moves A and B on the same edge.
    task automatic move(input logic [1:0] inc);
        ph_r <= ph_r + inc;
        repeat (4) @(posedge clk_in);
    endtask : move
    // A length under three edges is a spike to be filtered away.
    task automatic pulse_n(input int len,
                           input logic lvl = 1'b1);
        n_r <= lvl;
        repeat (len) @(posedge clk_in);
        n_r <= ~lvl;
        repeat (4) @(posedge clk_in);
    endtask : pulse_n
endmodule : enc_model

/* File: test/abn_quadrature_encoder_counter_sva.sv */
/* Bus handshake and interrupt checks for the encoder counter.
   Assumes it is bound to the counter and sees its ports only. */
`timescale 1ns/1ps
module abn_quadrature_encoder_counter_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic enc_n_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_rready_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    aw_busy_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        |=> !s_axi_awready_out) else $error("address taken twice");
    both_taken_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        && s_axi_wvalid_in && s_axi_wready_out
        |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
        else $error("write response timing off");
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    r_after_ar_a: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    bus_free_a: assert property (s_axi_rvalid_out && s_axi_rready_in
        |=> s_axi_arready_out && !s_axi_rvalid_out)
        else $error("read channel not freed");
    unmapped_read_a: assert property (s_axi_arvalid_in && s_axi_arready_out
        && s_axi_araddr_in > enc_pkg::OFS_MASK
        |=> s_axi_rresp_out == enc_pkg::RESP_SLVERR && s_axi_rdata_out == 0)
        else $error("unmapped read not refused");
    read_clr_a: assert property (s_axi_arvalid_in && s_axi_arready_out
        && s_axi_araddr_in == enc_pkg::OFS_STAT |=> !irq_out)
        else $error("status read left interrupt up");
    index_spike_a: assert property ($rose(irq_out) |-> s_axi_bvalid_out ||
        ($past(enc_n_in) == $past(enc_n_in, 2) &&
        $past(enc_n_in, 2) == $past(enc_n_in, 3)))
        else $error("interrupt without steady index");
    cover property (s_axi_bvalid_out && s_axi_bready_in);
    cover property (s_axi_rvalid_out && s_axi_rresp_out != 2'h0);
    cover property ($rose(irq_out));
endmodule : abn_quadrature_encoder_counter_sva
bind abn_quadrature_encoder_counter abn_quadrature_encoder_counter_sva
    #(.ADDR_W(ADDR_W)) sva_u (.mclk_in, .resetn_in, .enc_n_in,
    .s_axi_awvalid_in, .s_axi_wvalid_in, .s_axi_bready_in,
    .s_axi_arvalid_in, .s_axi_araddr_in, .s_axi_rready_in,
    .s_axi_awready_out, .s_axi_wready_out, .s_axi_bvalid_out,
    .s_axi_bresp_out, .s_axi_arready_out, .s_axi_rvalid_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .irq_out);

/* File: test/abn_quadrature_encoder_counter_tb_top.sv */
/* Bench for the encoder counter: bus master, encoder partner,
   result queue and watchdog. Assumes enc_pkg is compiled first. */
`timescale 1ns/1ps
module abn_quadrature_encoder_counter_tb_top;
    logic mclk_in, resetn_in, s_axi_awvalid_in, s_axi_wvalid_in;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, p;
    logic [3:0] s_axi_wstrb_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out, irq_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic enc_a_in, enc_b_in, enc_n_in;
    logic [33:0] got, want, exp_q[$];
    int mismatches = 0, total_checks = 0, seed = 44, r;
    abn_quadrature_encoder_counter #(.ADDR_W(8)) dut_u (.mclk_in,
        .resetn_in, .enc_a_in, .enc_b_in, .enc_n_in, .s_axi_awvalid_in,
        .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wdata_in,
        .s_axi_wstrb_in, .s_axi_bready_in, .s_axi_arvalid_in,
        .s_axi_araddr_in, .s_axi_rready_in, .s_axi_awready_out,
        .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bresp_out,
        .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .irq_out);
    enc_model enc_u (.clk_in(mclk_in), .a_out(enc_a_in),
        .b_out(enc_b_in), .n_out(enc_n_in));
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rs = enc_pkg::RESP_OKAY,
                      input logic [3:0] st = 4'hf);
        int h;
        @(posedge mclk_in);
        h = $random(seed);
        exp_q.push_back({rs, 32'h0000_0000});
        s_axi_awvalid_in <= 1'b1;
        s_axi_awaddr_in <= a;
        s_axi_wvalid_in <= 1'b1;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= st;
        s_axi_bready_in <= h[0];
        do begin
            @(posedge mclk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out && !s_axi_bready_in) begin
                s_axi_bready_in <= 1'b1;
            end
        end while (!(s_axi_bvalid_out && s_axi_bready_in));
        s_axi_bready_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] rs = enc_pkg::RESP_OKAY);
        int h;
        @(posedge mclk_in);
        h = $random(seed);
        exp_q.push_back({rs, v});
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in <= a;
        s_axi_rready_in <= h[0];
        do begin
            @(posedge mclk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out && !s_axi_rready_in) begin
                s_axi_rready_in <= 1'b1;
            end
        end while (!(s_axi_rvalid_out && s_axi_rready_in));
        s_axi_rready_in <= 1'b0;
    endtask : rd
    task automatic go(input int n, input logic [1:0] inc);
        repeat (n) enc_u.move(inc);
    endtask : go
    task automatic see_irq(input logic v);
        total_checks++;
        if (irq_out !== v) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time,
                     irq_out, v);
        end
    endtask : see_irq
    always @(posedge mclk_in) begin
        if ((s_axi_rvalid_out && s_axi_rready_in) ||
            (s_axi_bvalid_out && s_axi_bready_in)) begin
            got = s_axi_bvalid_out ? {s_axi_bresp_out, 32'h0000_0000}
                                   : {s_axi_rresp_out, s_axi_rdata_out};
            want = exp_q.pop_front();
            total_checks++;
            if (got !== want) begin
                mismatches++;
                $display("wrong value at %0t: got %h want %h", $time,
                         got, want);
            end
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #400_000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        resetn_in = 1'b0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        {s_axi_awaddr_in, s_axi_araddr_in} = 16'h0000;
        s_axi_wdata_in = 32'h0000_0000;
        s_axi_wstrb_in = 4'hf;
        repeat (2) @(posedge mclk_in);
        resetn_in <= 1'b1;
        rd(enc_pkg::OFS_MODE, 32'h0000_0000);
        rd(enc_pkg::OFS_STEP, enc_pkg::STEP_RST);
        rd(enc_pkg::OFS_LATCH, 32'h0000_0000);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        rd(enc_pkg::OFS_MASK, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000, enc_pkg::RESP_SLVERR);
        wr(8'h18, 32'hffff_ffff, enc_pkg::RESP_SLVERR);
        go(4, 2'h1);
        go(1, 2'h3);
        go(1, 2'h2);
        rd(enc_pkg::OFS_POS, 32'h0000_0003);
        wr(enc_pkg::OFS_STEP, 32'hffff_0000);
        go(2, 2'h1);
        rd(enc_pkg::OFS_POS, 32'h0000_0001);
        wr(enc_pkg::OFS_STEP, 32'h0000_8000);
        go(3, 2'h1);
        rd(enc_pkg::OFS_POS, 32'h0000_0002);
        go(2, 2'h3);
        rd(enc_pkg::OFS_POS, 32'h0000_0001);
        wr(enc_pkg::OFS_MASK, 32'h0000_0001);
        wr(enc_pkg::OFS_MODE, 32'h0000_0054);
        enc_u.pulse_n(4);
        see_irq(1'b1);
        rd(enc_pkg::OFS_LATCH, 32'h0000_0001);
        rd(enc_pkg::OFS_POS, 32'h0000_0000);
        rd(enc_pkg::OFS_STAT, 32'h0000_0001);
        see_irq(1'b0);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        enc_u.pulse_n(2);
        see_irq(1'b0);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        wr(enc_pkg::OFS_STEP, 32'h0001_0000);
        wr(enc_pkg::OFS_MODE, 32'h0000_005f);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        go(2, 2'h1);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_LATCH, 32'h0000_0002);
        rd(enc_pkg::OFS_STAT, 32'h0000_0001);
        wr(enc_pkg::OFS_MODE, 32'h0000_015f);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        wr(enc_pkg::OFS_MODE, 32'h0000_0064);
        go(1, 2'h1);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_MODE, 32'h0000_0044);
        go(1, 2'h1);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_POS, 32'h0000_0001);
        rd(enc_pkg::OFS_LATCH, 32'h0000_0001);
        see_irq(1'b1);
        wr(enc_pkg::OFS_MASK, 32'h0000_0000);
        see_irq(1'b0);
        wr(enc_pkg::OFS_MODE, 32'h0000_0014);
        go(2, 2'h1);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_LATCH, 32'h0000_0003);
        rd(enc_pkg::OFS_POS, 32'h0000_0003);
        wr(enc_pkg::OFS_STAT, 32'h0000_0001);
        rd(enc_pkg::OFS_STAT, 32'h0000_0000);
        wr(enc_pkg::OFS_MODE, 32'h0000_0080);
        wr(enc_pkg::OFS_STEP, 32'h0000_1388);
        go(3, 2'h1);
        rd(enc_pkg::OFS_POS, 32'h0000_0004);
        wr(enc_pkg::OFS_STEP, 32'hffe6_0fa0);
        go(1, 2'h1);
        rd(enc_pkg::OFS_POS, 32'hffff_ffea);
        go(1, 2'h1);
        rd(enc_pkg::OFS_POS, 32'hffff_ffd1);
        wr(enc_pkg::OFS_MODE, 32'h0000_0000);
        wr(enc_pkg::OFS_STEP, 32'h0001_0000);
        p = 32'hffff_ffd1;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            go(1, r[0] ? 2'h1 : 2'h3);
            p = r[0] ? p + 32'h0000_0001 : p - 32'h0000_0001;
        end
        rd(enc_pkg::OFS_POS, p);
        wr(enc_pkg::OFS_MODE, 32'h0000_0010);
        enc_u.pulse_n(4);
        rd(enc_pkg::OFS_LATCH, p);
        wr(enc_pkg::OFS_STEP, 32'h0007_0005, enc_pkg::RESP_OKAY, 4'h3);
        rd(enc_pkg::OFS_STEP, 32'h0001_0005);
        tally_and_finish();
    end
endmodule : abn_quadrature_encoder_counter_tb_top
